// ===== rtl/plap_pkg.sv
// package of register offsets, field masks and reset values for the port block
// assumes an 8-bit internal data bus with a 16-bit address
package plap_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [15:0] PLAP_OFS_PORT2_OUT   = 16'hff02;
   localparam logic [15:0] PLAP_OFS_PORT3_OUT   = 16'hff03;
   localparam logic [15:0] PLAP_OFS_PORT4_OUT   = 16'hff04;
   localparam logic [15:0] PLAP_OFS_PORT12_OUT  = 16'hff0c;
   localparam logic [15:0] PLAP_OFS_PORT13_OUT  = 16'hff0d;
   localparam logic [15:0] PLAP_OFS_PORT2_DIR   = 16'hff22;
   localparam logic [15:0] PLAP_OFS_PORT3_DIR   = 16'hff23;
   localparam logic [15:0] PLAP_OFS_PORT4_DIR   = 16'hff24;
   localparam logic [15:0] PLAP_OFS_PORT12_DIR  = 16'hff2c;
   localparam logic [15:0] PLAP_OFS_PORT2_PU    = 16'hff32;
   localparam logic [15:0] PLAP_OFS_PORT3_PU    = 16'hff33;
   localparam logic [15:0] PLAP_OFS_PORT4_PU    = 16'hff34;
   localparam logic [15:0] PLAP_OFS_PORT12_PU   = 16'hff3c;
   localparam logic [15:0] PLAP_OFS_PORT2_ASEL  = 16'hff84;
   // ****************************************
   // implemented bits of each port
   // ****************************************
   localparam logic [7:0]  PLAP_MASK_PORT2      = 8'h0f;
   localparam logic [7:0]  PLAP_MASK_PORT3      = 8'h13;
   localparam logic [7:0]  PLAP_MASK_PORT3_WR   = 8'h03;
   localparam logic [7:0]  PLAP_MASK_PORT4      = 8'h3f;
   localparam logic [7:0]  PLAP_MASK_PORT12     = 8'h0e;
   localparam logic [7:0]  PLAP_MASK_PORT13     = 8'h01;
   localparam logic [7:0]  PLAP_MASK_PU3        = 8'h03;
   localparam logic [7:0]  PLAP_MASK_PORT12_PULLUP_ENABLE       = 8'h08;
   localparam int          PLAP_BIT_RST_SHARED  = 4;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0]  PLAP_RST_LATCH       = 8'h00;
   localparam logic [7:0]  PLAP_RST_DIR         = 8'hff;
   localparam logic [7:0]  PLAP_RST_PU          = 8'h00;
   localparam logic [7:0]  PLAP_RST_ASEL        = 8'h00;
   typedef enum logic [4:0] {
      PLAP_P2  = 5'b00001,
      PLAP_P3  = 5'b00010,
      PLAP_P4  = 5'b00100,
      PLAP_P12 = 5'b01000,
      PLAP_P13 = 5'b10000
   } plap_port_e;
endpackage

// ===== rtl/plap_port_bit.sv
// one generic 8-bit port: latch, direction, pull-up and pin driver
// assumes pin inputs synchronous to sys_clk, write strobes one cycle long
module plap_port_bit
   import plap_pkg::*;
#(
   parameter logic [7:0] IMPL_MASK = 8'hff,
   parameter logic [7:0] WR_MASK   = 8'hff,
   parameter logic [7:0] PU_MASK   = 8'hff,
   parameter logic [7:0] DIR_MASK  = 8'hff
) (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       latch_wr,
   input  wire logic       dir_wr,
   input  wire logic       pu_wr,
   input  wire logic [7:0] wr_data,
   input  wire logic [7:0] pin_in,
   input  wire logic [7:0] analog_sel,
   output logic      [7:0] latch_q,
   output logic      [7:0] dir_q,
   output logic      [7:0] pu_q,
   output logic      [7:0] read_val,
   output logic      [7:0] pin_out,
   output logic      [7:0] pin_oe,
   output logic      [7:0] pullup_on
);
   logic [7:0] latch_reg;
   logic [7:0] latch_next;
   logic [7:0] dir_reg;
   logic [7:0] dir_next;
   logic [7:0] pu_reg;
   logic [7:0] pu_next;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      latch_next = latch_reg;
      dir_next   = dir_reg;
      pu_next    = pu_reg;
      if (latch_wr) begin
         latch_next = wr_data & WR_MASK;
      end
      if (dir_wr) begin
         dir_next = (wr_data & DIR_MASK) | ~DIR_MASK;
      end
      if (pu_wr) begin
         pu_next = wr_data & PU_MASK;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         latch_reg <= PLAP_RST_LATCH;
         dir_reg   <= PLAP_RST_DIR;
         pu_reg    <= PLAP_RST_PU;
      end else begin
         latch_reg <= latch_next;
         dir_reg   <= dir_next;
         pu_reg    <= pu_next;
      end
   end

   assign latch_q = latch_reg;
   assign dir_q   = dir_reg;
   assign pu_q    = pu_reg;

   assign read_val = ((dir_reg & pin_in) | (~dir_reg & latch_reg)) & IMPL_MASK;
   assign pin_oe   = ~dir_reg & ~analog_sel & WR_MASK;
   assign pin_out  = latch_reg & pin_oe;
   assign pullup_on = pu_reg & dir_reg & ~analog_sel & PU_MASK;
endmodule

// ===== rtl/plap_ports.sv
// parallel i/o port register block: latches, directions, pull-ups, analog select
// assumes a simple cpu memory port: one-cycle rd/wr strobes, byte data, 16-bit address;
// read data is registered and valid the cycle after the read strobe
module plap_ports
   import plap_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [15:0] cpu_addr,
   input  wire logic        cpu_wr,
   input  wire logic        cpu_rd,
   input  wire logic [7:0]  cpu_wdata,
   output logic      [7:0]  cpu_rdata,
   output logic             cpu_hit,
   input  wire logic [7:0]  port2_pin_in,
   input  wire logic [7:0]  port3_pin_in,
   input  wire logic [7:0]  port4_pin_in,
   input  wire logic [7:0]  port12_pin_in,
   output logic      [7:0]  port2_pin_out,
   output logic      [7:0]  port2_pin_oe,
   output logic      [7:0]  port3_pin_out,
   output logic      [7:0]  port3_pin_oe,
   output logic      [7:0]  port4_pin_out,
   output logic      [7:0]  port4_pin_oe,
   output logic      [7:0]  port12_pin_out,
   output logic      [7:0]  port12_pin_oe,
   output logic             port13_pin_out,
   output logic      [7:0]  port2_pullup_on,
   output logic      [7:0]  port3_pullup_on,
   output logic      [7:0]  port4_pullup_on,
   output logic      [7:0]  port12_pullup_on,
   output logic      [3:0]  analog_input_en
);
   // ****************************************
   // address decode
   // ****************************************
   function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
      hit = (a == ofs);
   endfunction

   logic [7:0] zero8;
   assign zero8 = 8'h00;

   logic [7:0] lat2, lat3, lat4, lat12, dir2, dir3, dir4, dir12;
   logic [7:0] pu2, pu3, pu4, port12_pullup_enable;
   logic [7:0] rd2, rd3, rd4, rd12;
   logic [7:0] p3_oe_raw, p3_out_raw;

   logic [7:0] asel_reg;
   logic [7:0] asel_next;
   logic       p13_reg;
   logic       p13_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       hit_reg;
   logic       hit_next;
   logic       rst_bit;

   // ****************************************
   // per-port latches
   // ****************************************
   // port2 bits 0-3
   plap_port_bit #(
      .IMPL_MASK (PLAP_MASK_PORT2),
      .WR_MASK   (PLAP_MASK_PORT2),
      .PU_MASK   (PLAP_MASK_PORT2),
      .DIR_MASK  (PLAP_MASK_PORT2)
   ) u_port2 (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .latch_wr  (cpu_wr && hit(cpu_addr, PLAP_OFS_PORT2_OUT)),
      .dir_wr    (cpu_wr && hit(cpu_addr, PLAP_OFS_PORT2_DIR)),
      .pu_wr     (cpu_wr && hit(cpu_addr, PLAP_OFS_PORT2_PU)),
      .wr_data   (cpu_wdata),
      .pin_in    (port2_pin_in),
      .analog_sel(asel_reg),
      .latch_q   (lat2),
      .dir_q     (dir2),
      .pu_q      (pu2),
      .read_val  (rd2),
      .pin_out   (port2_pin_out),
      .pin_oe    (port2_pin_oe),
      .pullup_on (port2_pullup_on)
   );

   plap_port_bit #(
      .IMPL_MASK (PLAP_MASK_PORT3_WR),
      .WR_MASK   (PLAP_MASK_PORT3_WR),
      .PU_MASK   (PLAP_MASK_PU3),
      .DIR_MASK  (PLAP_MASK_PORT3_WR)
   ) u_port3 (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .latch_wr  (cpu_wr && hit(cpu_addr, PLAP_OFS_PORT3_OUT)),
      .dir_wr    (cpu_wr && hit(cpu_addr, PLAP_OFS_PORT3_DIR)),
      .pu_wr     (cpu_wr && hit(cpu_addr, PLAP_OFS_PORT3_PU)),
      .wr_data   (cpu_wdata),
      .pin_in    (port3_pin_in),
      .analog_sel(zero8),
      .latch_q   (lat3),
      .dir_q     (dir3),
      .pu_q      (pu3),
      .read_val  (rd3),
      .pin_out   (p3_out_raw),
      .pin_oe    (p3_oe_raw),
      .pullup_on (port3_pullup_on)
   );
   assign port3_pin_out = p3_out_raw;
   assign port3_pin_oe  = p3_oe_raw;

   plap_port_bit #(
      .IMPL_MASK (PLAP_MASK_PORT4),
      .WR_MASK   (PLAP_MASK_PORT4),
      .PU_MASK   (PLAP_MASK_PORT4),
      .DIR_MASK  (PLAP_MASK_PORT4)
   ) u_port4 (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .latch_wr  (cpu_wr && hit(cpu_addr, PLAP_OFS_PORT4_OUT)),
      .dir_wr    (cpu_wr && hit(cpu_addr, PLAP_OFS_PORT4_DIR)),
      .pu_wr     (cpu_wr && hit(cpu_addr, PLAP_OFS_PORT4_PU)),
      .wr_data   (cpu_wdata),
      .pin_in    (port4_pin_in),
      .analog_sel(zero8),
      .latch_q   (lat4),
      .dir_q     (dir4),
      .pu_q      (pu4),
      .read_val  (rd4),
      .pin_out   (port4_pin_out),
      .pin_oe    (port4_pin_oe),
      .pullup_on (port4_pullup_on)
   );

   plap_port_bit #(
      .IMPL_MASK (PLAP_MASK_PORT12),
      .WR_MASK   (PLAP_MASK_PORT12),
      .PU_MASK   (PLAP_MASK_PORT12_PULLUP_ENABLE),
      .DIR_MASK  (PLAP_MASK_PORT12)
   ) u_port12 (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .latch_wr  (cpu_wr && hit(cpu_addr, PLAP_OFS_PORT12_OUT)),
      .dir_wr    (cpu_wr && hit(cpu_addr, PLAP_OFS_PORT12_DIR)),
      .pu_wr     (cpu_wr && hit(cpu_addr, PLAP_OFS_PORT12_PU)),
      .wr_data   (cpu_wdata),
      .pin_in    (port12_pin_in),
      .analog_sel(zero8),
      .latch_q   (lat12),
      .dir_q     (dir12),
      .pu_q      (port12_pullup_enable),
      .read_val  (rd12),
      .pin_out   (port12_pin_out),
      .pin_oe    (port12_pin_oe),
      .pullup_on (port12_pullup_on)
   );

   // reset-shared input bit always reads pin
   assign rst_bit = port3_pin_in[PLAP_BIT_RST_SHARED];

   // ****************************************
   // analog select, port13, read mux
   // ****************************************
   always_comb begin
      asel_next  = asel_reg;
      p13_next   = p13_reg;
      rdata_next = rdata_reg;
      hit_next   = 1'b0;
      if (cpu_wr && hit(cpu_addr, PLAP_OFS_PORT2_ASEL)) begin
         asel_next = cpu_wdata & PLAP_MASK_PORT2;
      end
      if (cpu_wr && hit(cpu_addr, PLAP_OFS_PORT13_OUT)) begin
         p13_next = cpu_wdata[0];
      end
      if (cpu_rd) begin
         hit_next = 1'b1;
         case (cpu_addr)
            PLAP_OFS_PORT2_OUT:  rdata_next = rd2;
            PLAP_OFS_PORT3_OUT: begin
               rdata_next = rd3;
               rdata_next[PLAP_BIT_RST_SHARED] = rst_bit;
            end
            PLAP_OFS_PORT4_OUT:  rdata_next = rd4;
            PLAP_OFS_PORT12_OUT: rdata_next = rd12;
            PLAP_OFS_PORT13_OUT: rdata_next = {7'h00, p13_reg};
            PLAP_OFS_PORT2_DIR:  rdata_next = dir2;
            PLAP_OFS_PORT3_DIR:  rdata_next = dir3;
            PLAP_OFS_PORT4_DIR:  rdata_next = dir4;
            PLAP_OFS_PORT12_DIR: rdata_next = dir12;
            PLAP_OFS_PORT2_PU:   rdata_next = pu2;
            PLAP_OFS_PORT3_PU:   rdata_next = pu3;
            PLAP_OFS_PORT4_PU:   rdata_next = pu4;
            PLAP_OFS_PORT12_PU:  rdata_next = port12_pullup_enable;
            PLAP_OFS_PORT2_ASEL: rdata_next = asel_reg;
            default: begin
               rdata_next = 8'h00;
               hit_next   = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         asel_reg  <= PLAP_RST_ASEL;
         p13_reg   <= 1'b0;
         rdata_reg <= 8'h00;
         hit_reg   <= 1'b0;
      end else begin
         asel_reg  <= asel_next;
         p13_reg   <= p13_next;
         rdata_reg <= rdata_next;
         hit_reg   <= hit_next;
      end
   end

   assign cpu_rdata       = rdata_reg;
   assign cpu_hit         = hit_reg;
   assign port13_pin_out  = p13_reg;
   assign analog_input_en = asel_reg[3:0];
endmodule

// ===== testbench/plap_ports_monitor.sv
// checker bound to the port register block, sees its top-level ports
// assumes rising-edge sys_clk and synchronous active-high sys_rst
module plap_ports_monitor
   import plap_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [15:0] cpu_addr,
   input wire logic        cpu_wr,
   input wire logic        cpu_rd,
   input wire logic [7:0]  cpu_wdata,
   input wire logic [7:0]  cpu_rdata,
   input wire logic        cpu_hit,
   input wire logic [7:0]  port2_pin_out,
   input wire logic [7:0]  port2_pin_oe,
   input wire logic [7:0]  port4_pin_oe,
   input wire logic        port13_pin_out,
   input wire logic [7:0]  port2_pullup_on,
   input wire logic [7:0]  port4_pullup_on,
   input wire logic [3:0]  analog_input_en
);
   // ****************************************
   // port checks
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_rd(logic [15:0] a);
      cpu_rd && !cpu_wr && cpu_addr == a;
   endsequence
   sequence s_wr(logic [15:0] a);
      cpu_wr && cpu_addr == a;
   endsequence
   a_reset_idle: assert property (disable iff (1'b0)
      sys_rst |=> port2_pin_oe == 8'h00 && port4_pullup_on == 8'h00
         && analog_input_en == 4'h0 && !port13_pin_out && !cpu_hit)
      else $error("outputs not idle after reset");
   a_out_needs_oe: assert property ((port2_pin_out & ~port2_pin_oe) == 8'h00)
      else $error("port2 level without enable");
   a_analog_off: assert property (|analog_input_en |->
      ((port2_pin_oe[3:0] | port2_pullup_on[3:0]) & analog_input_en) == 4'h0)
      else $error("analog pin still digital");
   a_pullup_input: assert property (((port2_pullup_on & port2_pin_oe)
      | (port4_pullup_on & port4_pin_oe)) == 8'h00)
      else $error("pull-up on an output pin");
   a_analog_load: assert property (s_wr(PLAP_OFS_PORT2_ASEL) |=>
      {4'h0, analog_input_en} == ($past(cpu_wdata) & 8'h0f))
      else $error("analog select not loaded");
   a_p13_load: assert property (s_wr(PLAP_OFS_PORT13_OUT) |=>
      {7'h00, port13_pin_out} == ($past(cpu_wdata) & 8'h01))
      else $error("port13 latch not loaded");
   a_p13_read: assert property (s_rd(PLAP_OFS_PORT13_OUT) |=>
      cpu_hit && cpu_rdata == {7'h00, port13_pin_out})
      else $error("port13 read differs");
   a_latch_hold: assert property (!cpu_wr |=>
      $stable(port2_pin_out) && $stable(port13_pin_out))
      else $error("output moved without write");
endmodule
bind plap_ports plap_ports_monitor plap_ports_monitor_i (.*);

// ===== testbench/plap_pin_model.sv
// devices wired to one 8-bit port: drive, pull-up, or float
// assumes ext_val and ext_en are set by the bench at the falling edge
module plap_pin_model (
   input  wire logic       sys_clk,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pullup_on,
   input  wire logic [7:0] ext_val,
   input  wire logic [7:0] ext_en,
   output logic      [7:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // wire level
   // ****************************************
   logic [7:0] flt_reg = 8'h55;
   // undriven pins without pull-up wander every cycle
   always @(posedge sys_clk) flt_reg <= ~flt_reg;
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en & (pullup_on | flt_reg));
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the port register block
// assumes design, pin model and bound checker compiled before it
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // stimulus and checks
   // ****************************************
   logic        sys_clk   = 1'b0;
   logic        sys_rst   = 1'b1;
   logic        cpu_wr    = 1'b0;
   logic        cpu_rd    = 1'b0;
   logic        cpu_hit;
   logic        p13_out;
   logic        hv;
   logic [15:0] cpu_addr  = 16'h0000;
   logic [7:0]  cpu_wdata = 8'h00;
   logic [7:0]  cpu_rdata;
   logic [7:0]  rv;
   logic [3:0]  asel_en;
   logic [7:0]  pin_in [4];
   logic [7:0]  pin_out [4];
   logic [7:0]  pin_oe [4];
   logic [7:0]  pu_on [4];
   logic [7:0]  ext_v [4] = '{8'h0a, 8'h00, 8'h00, 8'h00};
   logic [7:0]  ext_e [4] = '{default: 8'hff};
   int          mismatches = 0;
   int          n_checks   = 0;
   int          cyc        = 0;
   localparam logic [15:0] OUT_A [4] = '{16'hff02, 16'hff03, 16'hff04, 16'hff0c};
   localparam logic [15:0] DIR_A [4] = '{16'hff22, 16'hff23, 16'hff24, 16'hff2c};
   localparam logic [15:0] PU_A  [4] = '{16'hff32, 16'hff33, 16'hff34, 16'hff3c};
   localparam logic [7:0]  MSK   [4] = '{8'h0f, 8'h03, 8'h3f, 8'h0e};
   localparam logic [7:0]  PMSK  [4] = '{8'h0f, 8'h03, 8'h3f, 8'h08};
   plap_ports plap_ports_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .cpu_addr(cpu_addr),
      .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .cpu_hit(cpu_hit), .port2_pin_in(pin_in[0]), .port3_pin_in(pin_in[1]),
      .port4_pin_in(pin_in[2]), .port12_pin_in(pin_in[3]), .port2_pin_out(pin_out[0]),
      .port2_pin_oe(pin_oe[0]), .port3_pin_out(pin_out[1]), .port3_pin_oe(pin_oe[1]),
      .port4_pin_out(pin_out[2]), .port4_pin_oe(pin_oe[2]), .port12_pin_out(pin_out[3]),
      .port12_pin_oe(pin_oe[3]), .port13_pin_out(p13_out), .port2_pullup_on(pu_on[0]),
      .port3_pullup_on(pu_on[1]), .port4_pullup_on(pu_on[2]),
      .port12_pullup_on(pu_on[3]), .analog_input_en(asel_en));
   for (genvar i = 0; i < 4; i++) begin : g_pin
      plap_pin_model plap_pin_model_i (.sys_clk(sys_clk), .pin_out(pin_out[i]),
         .pin_oe(pin_oe[i]), .pullup_on(pu_on[i]), .ext_val(ext_v[i]),
         .ext_en(ext_e[i]), .pin_in(pin_in[i]));
   end
   always #10 sys_clk = ~sys_clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      cpu_addr  = a;
      cpu_wdata = d;
      cpu_wr    = 1'b1;
      @(negedge sys_clk);
      cpu_wr = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a);
      @(negedge sys_clk);
      cpu_addr = a;
      cpu_rd   = 1'b1;
      @(negedge sys_clk);
      cpu_rd = 1'b0;
      rv     = cpu_rdata;
      hv     = cpu_hit;
   endtask
   task automatic rdc(input logic [15:0] a, input logic [7:0] e);
      rd(a);
      chk(rv, e);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 2000) begin
         mismatches++;
         wrap_up();
      end
   end
   initial begin
      repeat (5) @(negedge sys_clk);
      sys_rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         rdc(PU_A[i], 8'h00);
         rdc(DIR_A[i], 8'hff);
         chk(pin_oe[i], 8'h00);
      end
      rdc(16'hff84, 8'h00);
      rdc(16'hff0d, 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         wr(DIR_A[i], 8'h00);
         rdc(OUT_A[i], 8'h00);
         wr(OUT_A[i], 8'hff);
         rdc(OUT_A[i], MSK[i]);
         chk(pin_out[i], MSK[i]);
         rdc(DIR_A[i], ~MSK[i]);
      end
      ext_v[1] = 8'h10;
      rdc(16'hff03, 8'h13);
      $display("test output mode done");
      wr(16'hff22, 8'hff);
      chk(pin_oe[0], 8'h00);
      rdc(16'hff02, 8'h0a);
      wr(16'hff02, 8'h05);
      chk(pin_in[0], 8'h0a);
      wr(16'hff22, 8'h00);
      chk(pin_out[0], 8'h05);
      wr(16'hff22, 8'hff);
      rd(16'hff02);
      wr(16'hff02, rv | 8'h01);
      wr(16'hff22, 8'h00);
      chk(pin_out[0], 8'h0b);
      $display("test input mode done");
      ext_e = '{default: 8'h00};
      for (int i = 0; i < 4; i++) begin
         wr(DIR_A[i], 8'hff);
         wr(PU_A[i], 8'hff);
         rdc(PU_A[i], PMSK[i]);
         chk(pu_on[i], PMSK[i]);
      end
      rdc(16'hff02, 8'h0f);
      wr(16'hff24, 8'h00);
      chk(pu_on[2], 8'h00);
      wr(16'hff84, 8'hff);
      rdc(16'hff84, 8'h0f);
      chk({4'h0, asel_en}, 8'h0f);
      chk(pu_on[0], 8'h00);
      wr(16'hff22, 8'h00);
      chk(pin_oe[0], 8'h00);
      // software releases the pull-ups of analog pins
      wr(16'hff32, 8'h00);
      rdc(16'hff32, 8'h00);
      chk(pu_on[0], 8'h00);
      // timer output on port3 bit1: output direction, latch 0
      wr(16'hff23, 8'hfd);
      wr(16'hff03, 8'h00);
      chk(pin_oe[1], 8'h02);
      chk(pin_out[1], 8'h00);
      // serial transmit on port4 bit3: output direction, latch 1
      wr(16'hff24, 8'hf7);
      wr(16'hff04, 8'h08);
      chk(pin_oe[2], 8'h08);
      chk(pin_out[2], 8'h08);
      $display("test pull-up and analog done");
      wr(16'hff0d, 8'hff);
      chk({7'h00, p13_out}, 8'h01);
      rdc(16'hff0d, 8'h01);
      chk({7'h00, hv}, 8'h01);
      rdc(16'h1234, 8'h00);
      chk({7'h00, hv}, 8'h00);
      $display("test port13 and unmapped done");
      // second reset in mid-run clears latches and select and sets directions back to all-input
      @(negedge sys_clk);
      sys_rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b0;
      chk(pin_oe[2], 8'h00);
      chk({4'h0, asel_en}, 8'h00);
      rdc(16'hff0d, 8'h00);
      rdc(16'hff24, 8'hff);
      wr(16'hff24, 8'h00);
      rdc(16'hff04, 8'h00);
      rdc(16'hff34, 8'h00);
      $display("test mid-run reset done");
      wrap_up();
   end
endmodule
